/* File: core/msc_system_control.sv */
// Contract
// RULE_01: microsequencer runs data handling only while bit 00 is one.
// RULE_02: bits 04-05 become address bits 16-17 of selected line's loaded address.
// RULE_03: software writes extended bits before loading the secondary address.
// RULE_04: reading bits 04-05 returns last written value, not per-line bits.
// RULE_05: bit 06 enables bit 07 onto a host interrupt.
// RULE_06: device sets bit 07 on reception; writable only while bit 09 is one.
// RULE_07: software reads interrupt character, may load control byte, then sets bit 08.
// RULE_08: writing one to bit 08 clears bit 07 and resumes servicing.
// RULE_09: bit 10 sets when transfer-status silo holds 64 unread entries.
// RULE_10: bit 10 interrupts only while bit 12 is one; both read/write.
// RULE_11: writing bit 11 clears listed bits and other registers, then self-clears.
// RULE_12: bit 15 interrupts only while bit 13 is one.
// RULE_13: bit 15 sets on transmit-interrupt status load, clears on status read.
// RULE_14: bits 07 and 15 are writable only while bit 09 is one.
// RULE_15: receive uses vector A; transfer-status and overflow use vector B.
// RULE_16: bus initialize clears all control and flag bits of this register.
// RULE_17: software selects the line by writing its number to select bits 00-03.
// RULE_18: interrupt requests are levels held while flag and enable are both one; irq holds sticky status until written to the clear offset.
// RULE_19: bit 14 ignores writes and reads as zero.
module msc_system_control (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic [msc_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [msc_pkg::DATA_W-1:0] regWrData,
    input  wire logic                       regWrStrobe,
    input  wire logic                       regRdStrobe,
    output logic      [msc_pkg::DATA_W-1:0] regRdData,
    input  wire logic                       rxEvent,
    input  wire logic                       xsLoad,
    input  wire logic                       xsTxInt,
    input  wire logic                       xsRead,
    input  wire logic                       secAddrLoad,
    output logic                            seqRun,
    output logic                            serviceGo,
    output logic                            masterClear,
    output logic      [1:0]                 extAddrHi,
    output logic      [1:0]                 selLineExtAddr,
    output logic      [msc_pkg::LINE_W-1:0] selectedLine,
    output logic                            irqVectorA,
    output logic                            irqVectorB,
    output logic                            irq
);
    import msc_pkg::*;

    logic [DATA_W-1:0] scr_ff;
    logic [DATA_W-1:0] nxt_scr;
    logic              svcGo_ff;
    logic              nxt_svcGo;
    logic [LINE_W-1:0] secSel_ff;
    logic [LINE_W-1:0] nxt_secSel;
    logic [CNT_W-1:0]  siloCnt_ff;
    logic [CNT_W-1:0]  nxt_siloCnt;
    logic [DATA_W-1:0] rdData_ff;
    logic [DATA_W-1:0] nxt_rdData;
    logic [1:0]        lineXa_ff [LINES];
    logic [1:0]        nxt_lineXa [LINES];
    logic              scrWr;
    logic              rxSet;
    logic              xsSet;
    logic [EVT_W-1:0]  evtPulse;
    logic [EVT_W-1:0]  irqStatus;
    logic [EVT_W-1:0]  irqEnable;

    assign scrWr = regWrStrobe && (regAddr == OFF_SYS_CTRL);
    assign rxSet = rxEvent && scr_ff[B_GO];                   // RULE_01
    assign xsSet = xsLoad && xsTxInt && scr_ff[B_GO];         // RULE_01

    // ------------------------------------------------------------
    // system control register
    // ------------------------------------------------------------
    always_comb begin
        nxt_scr           = scr_ff;
        nxt_svcGo         = 1'b0;
        nxt_scr[B_MCLR]   = 1'b0;                             // RULE_11
        if (scrWr) begin
            nxt_scr[B_GO]             = regWrData[B_GO];
            nxt_scr[B_XA_HI:B_XA_LO]  = regWrData[B_XA_HI:B_XA_LO];   // RULE_04
            nxt_scr[B_RX_IE]          = regWrData[B_RX_IE];
            nxt_scr[B_SVC_DONE]       = regWrData[B_SVC_DONE];
            nxt_scr[B_MAINT_WE]       = regWrData[B_MAINT_WE];
            nxt_scr[B_OVF_FLAG]       = regWrData[B_OVF_FLAG];        // RULE_10
            nxt_scr[B_OVF_IE]         = regWrData[B_OVF_IE];          // RULE_10
            nxt_scr[B_XS_IE]          = regWrData[B_XS_IE];
            // bits 07 and 15 are status, so only the maintenance enable opens them
            if (scr_ff[B_MAINT_WE]) begin
                nxt_scr[B_RX_FLAG] = regWrData[B_RX_FLAG];            // RULE_14
                nxt_scr[B_XS_FLAG] = regWrData[B_XS_FLAG];            // RULE_14
            end
            if (regWrData[B_SVC_DONE]) begin
                nxt_scr[B_RX_FLAG] = 1'b0;                            // RULE_08
                nxt_svcGo          = 1'b1;                            // RULE_08
            end
            if (regWrData[B_MCLR]) begin
                nxt_scr         = nxt_scr & ~MCLR_MASK;               // RULE_11
                nxt_scr[B_MCLR] = 1'b1;
            end
        end
        if (xsRead) begin
            nxt_scr[B_XS_FLAG] = 1'b0;                                // RULE_13
        end
        // hardware sets come last so they win over any clear
        if (rxSet) begin
            nxt_scr[B_RX_FLAG] = 1'b1;                                // RULE_06
        end
        if (siloCnt_ff == SILO_DEPTH) begin
            nxt_scr[B_OVF_FLAG] = 1'b1;                               // RULE_09
        end
        if (xsSet) begin
            nxt_scr[B_XS_FLAG] = 1'b1;                                // RULE_13
        end
        nxt_scr = nxt_scr & READ_MASK;                                // RULE_19
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scr_ff   <= SYS_CTRL_RESET;                               // RULE_16
            svcGo_ff <= 1'b0;
        end else begin
            scr_ff   <= nxt_scr;
            svcGo_ff <= nxt_svcGo;
        end
    end

    // ------------------------------------------------------------
    // transfer-status silo occupancy
    // ------------------------------------------------------------
    always_comb begin
        nxt_siloCnt = siloCnt_ff;
        if (xsLoad && !xsRead && siloCnt_ff != SILO_DEPTH) begin
            nxt_siloCnt = siloCnt_ff + 7'h01;                         // RULE_09
        end else if (xsRead && !xsLoad && siloCnt_ff != 7'h00) begin
            nxt_siloCnt = siloCnt_ff - 7'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            siloCnt_ff <= 7'h00;
        end else begin
            siloCnt_ff <= nxt_siloCnt;
        end
    end

    // ------------------------------------------------------------
    // line select and per-line extended address bits
    // ------------------------------------------------------------
    always_comb begin
        nxt_secSel = secSel_ff;
        if (regWrStrobe && regAddr == OFF_SEC_SEL) begin
            nxt_secSel = regWrData[LINE_W-1:0];                       // RULE_17
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            secSel_ff <= SEC_SEL_RESET;
        end else begin
            secSel_ff <= nxt_secSel;
        end
    end

    // bits are taken at the load, so a late write to 04-05 misses it
    for (genvar i = 0; i < LINES; i++) begin : g_line
        always_comb begin
            nxt_lineXa[i] = lineXa_ff[i];
            if (secAddrLoad && secSel_ff == LINE_W'(i)) begin
                nxt_lineXa[i] = scr_ff[B_XA_HI:B_XA_LO];              // RULE_02 RULE_03
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                lineXa_ff[i] <= 2'h0;
            end else begin
                lineXa_ff[i] <= nxt_lineXa[i];
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdData = 16'h0000;
        if (regRdStrobe) begin
            if (regAddr == OFF_SYS_CTRL) begin
                nxt_rdData = scr_ff & READ_MASK;                      // RULE_04 RULE_19
            end else if (regAddr == OFF_SEC_SEL) begin
                nxt_rdData = {12'h000, secSel_ff};
            end else if (regAddr == OFF_IRQ_STATUS) begin
                nxt_rdData = {13'h0, irqStatus};
            end else if (regAddr == OFF_IRQ_ENABLE) begin
                nxt_rdData = {13'h0, irqEnable};
            end else begin
                nxt_rdData = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_ff <= 16'h0000;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // ------------------------------------------------------------
    // interrupt summary
    // ------------------------------------------------------------
    assign evtPulse[EV_RX]  = nxt_scr[B_RX_FLAG] && !scr_ff[B_RX_FLAG];
    assign evtPulse[EV_OVF] = nxt_scr[B_OVF_FLAG] && !scr_ff[B_OVF_FLAG];
    assign evtPulse[EV_XS]  = nxt_scr[B_XS_FLAG] && !scr_ff[B_XS_FLAG];

    msc_irq_unit u_irq (
        .clk      (clk),
        .reset_n  (reset_n),
        .evtPulse (evtPulse),
        .clrWr    (regWrStrobe && regAddr == OFF_IRQ_CLEAR),
        .enWr     (regWrStrobe && regAddr == OFF_IRQ_ENABLE),
        .wrBits   (regWrData[EVT_W-1:0]),
        .status   (irqStatus),
        .enable   (irqEnable),
        .irq      (irq)
    );

    assign irqVectorA = scr_ff[B_RX_FLAG] && scr_ff[B_RX_IE];         // RULE_05 RULE_15 RULE_18
    assign irqVectorB = (scr_ff[B_OVF_FLAG] && scr_ff[B_OVF_IE])      // RULE_10 RULE_15
                     || (scr_ff[B_XS_FLAG] && scr_ff[B_XS_IE]);       // RULE_12 RULE_18

    assign regRdData      = rdData_ff;
    assign seqRun         = scr_ff[B_GO];                             // RULE_01
    assign serviceGo      = svcGo_ff;
    assign masterClear    = scr_ff[B_MCLR];                           // RULE_11
    assign extAddrHi      = scr_ff[B_XA_HI:B_XA_LO];
    assign selLineExtAddr = lineXa_ff[secSel_ff];
    assign selectedLine   = secSel_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_scr_write;
        scrWr;
    endsequence

    sequence s_scr_read;
        regRdStrobe && regAddr == OFF_SYS_CTRL && !regWrStrobe;
    endsequence

    // a pulse may only stretch when the next cycle repeats the write
    sequence s_svc_pulse;
        serviceGo ##1 (serviceGo == $past(scrWr && regWrData[B_SVC_DONE]));
    endsequence

    sequence s_mclr_pulse;
        masterClear ##1 (masterClear == $past(scrWr && regWrData[B_MCLR]));
    endsequence

    AST_GO_RUN: assert property (scrWr && regWrData[B_GO] && !regWrData[B_MCLR] |=> seqRun) // RULE_01
        else $error("run bit not set by write");
    AST_IDLE: assert property (!seqRun && !scrWr // RULE_01
        |=> !$rose(scr_ff[B_RX_FLAG]) && !$rose(scr_ff[B_XS_FLAG]))
        else $error("flag raised while stopped");
    AST_LINE_XA: assert property (secAddrLoad && !(regWrStrobe && regAddr == OFF_SEC_SEL) // RULE_02
        |=> selLineExtAddr == $past(extAddrHi))
        else $error("line extended bits not taken at load");
    AST_XA_READ: assert property (s_scr_write ##1 !scrWr ##1 s_scr_read // RULE_04
        |=> regRdData[B_XA_HI:B_XA_LO] == $past(regWrData[B_XA_HI:B_XA_LO], 3))
        else $error("extended field read differs from write");
    AST_VEC_A: assert property (rxSet && scr_ff[B_RX_IE] && !scrWr |=> irqVectorA) // RULE_05
        else $error("vector A missing for receive interrupt");
    AST_RX_SET: assert property (rxEvent && seqRun // RULE_06
        |=> scr_ff[B_RX_FLAG] ##0 irqVectorA == scr_ff[B_RX_IE])
        else $error("receive flag or vector A wrong");
    AST_RX_RO: assert property (scrWr && !scr_ff[B_MAINT_WE] && !regWrData[B_SVC_DONE] // RULE_06
        && !regWrData[B_MCLR] && !rxSet |=> scr_ff[B_RX_FLAG] == $past(scr_ff[B_RX_FLAG]))
        else $error("bit 07 written without write enable");
    AST_SVC: assert property (scrWr && regWrData[B_SVC_DONE] && !rxSet // RULE_08
        |=> !scr_ff[B_RX_FLAG] ##0 s_svc_pulse)
        else $error("service complete did not clear flag");
    AST_OVF: assert property (siloCnt_ff == SILO_DEPTH |=> scr_ff[B_OVF_FLAG]) // RULE_09
        else $error("overflow flag not set when silo full");
    AST_OVF_IE: assert property (siloCnt_ff == SILO_DEPTH && scr_ff[B_OVF_IE] && !scrWr |=> irqVectorB) // RULE_10
        else $error("vector B missing for overflow");
    AST_MCLR: assert property (scrWr && regWrData[B_MCLR] && !rxSet && !xsSet // RULE_11
        && siloCnt_ff != SILO_DEPTH |=> !seqRun && !irqVectorA && !irqVectorB ##0 s_mclr_pulse)
        else $error("master clear misbehaved");
    AST_XS_CLR: assert property (xsRead && !xsSet |=> !scr_ff[B_XS_FLAG]) // RULE_13
        else $error("status read did not clear bit 15");
    AST_RO: assert property (scrWr && !scr_ff[B_MAINT_WE] && !regWrData[B_MCLR] && !xsRead && !xsSet // RULE_14
        |=> scr_ff[B_XS_FLAG] == $past(scr_ff[B_XS_FLAG]))
        else $error("bit 15 written without write enable");
    AST_MAINT_WR: assert property (scrWr && scr_ff[B_MAINT_WE] && !regWrData[B_MCLR] && !xsRead // RULE_14
        && !xsSet
        |=> scr_ff[B_XS_FLAG] == $past(regWrData[B_XS_FLAG]))
        else $error("bit 15 not written with write enable");
    AST_VEC_B: assert property ($rose(scr_ff[B_XS_FLAG]) && scr_ff[B_XS_IE] |-> irqVectorB) // RULE_12
        else $error("vector B missing for status interrupt");
    AST_RD_ZERO: assert property (!regRdStrobe |=> regRdData == 16'h0000) // RULE_04
        else $error("read data stands beyond its cycle");
    AST_UNUSED: assert property (regRdData[14] == 1'b0) // RULE_19
        else $error("unused bit reads one");
endmodule : msc_system_control

/* File: core/msc_pkg.sv */
package msc_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int LINES  = 16;
    localparam int LINE_W = 4;
    localparam int EVT_W  = 3;
    localparam int CNT_W  = 7;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_SYS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_SEC_SEL    = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 4'h4;

    // ------------------------------------------------------------
    // system control field positions
    // ------------------------------------------------------------
    localparam int B_GO       = 0;
    localparam int B_XA_LO    = 4;
    localparam int B_XA_HI    = 5;
    localparam int B_RX_IE    = 6;
    localparam int B_RX_FLAG  = 7;
    localparam int B_SVC_DONE = 8;
    localparam int B_MAINT_WE = 9;
    localparam int B_OVF_FLAG = 10;
    localparam int B_MCLR     = 11;
    localparam int B_OVF_IE   = 12;
    localparam int B_XS_IE    = 13;
    localparam int B_XS_FLAG  = 15;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] SYS_CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] MCLR_MASK      = 16'hbecf;
    localparam logic [DATA_W-1:0] READ_MASK      = 16'hbff1;
    localparam logic [LINE_W-1:0] SEC_SEL_RESET  = 4'h0;
    localparam logic [EVT_W-1:0]  IRQ_RESET      = 3'h0;

    // ------------------------------------------------------------
    // event indices and silo depth
    // ------------------------------------------------------------
    localparam int EV_RX  = 0;
    localparam int EV_OVF = 1;
    localparam int EV_XS  = 2;
    localparam logic [CNT_W-1:0] SILO_DEPTH = 7'h40;
endpackage : msc_pkg

/* File: core/msc_irq_unit.sv */
module msc_irq_unit (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic [msc_pkg::EVT_W-1:0] evtPulse,
    input  wire logic                      clrWr,
    input  wire logic                      enWr,
    input  wire logic [msc_pkg::EVT_W-1:0] wrBits,
    output logic      [msc_pkg::EVT_W-1:0] status,
    output logic      [msc_pkg::EVT_W-1:0] enable,
    output logic                           irq
);
    import msc_pkg::*;

    logic [EVT_W-1:0] status_ff;
    logic [EVT_W-1:0] enable_ff;
    logic [EVT_W-1:0] nxt_status;
    logic [EVT_W-1:0] nxt_enable;

    // ------------------------------------------------------------
    // sticky bits, set beats clear in the same cycle
    // ------------------------------------------------------------
    for (genvar i = 0; i < EVT_W; i++) begin : g_bit
        always_comb begin
            nxt_status[i] = status_ff[i];
            nxt_enable[i] = enable_ff[i];
            if (clrWr && wrBits[i]) begin
                nxt_status[i] = 1'b0;
            end
            if (evtPulse[i]) begin
                nxt_status[i] = 1'b1;
            end
            if (enWr) begin
                nxt_enable[i] = wrBits[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= IRQ_RESET;
            enable_ff <= IRQ_RESET;
        end else begin
            status_ff <= nxt_status;
            enable_ff <= nxt_enable;
        end
    end

    assign status = status_ff;
    assign enable = enable_ff;
    assign irq    = |(status_ff & enable_ff);
endmodule : msc_irq_unit

/* File: testbench/msc_seq_model.sv */
module msc_seq_model (
    input  wire logic clk,
    output logic      rxEvent,
    output logic      xsLoad,
    output logic      xsTxInt,
    output logic      xsRead,
    output logic      secAddrLoad
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // microsequencer event source
    // ------------------------------------------------------------
    // event lines idle low between pulses, never left at last value
    initial begin
        {secAddrLoad, xsRead, xsTxInt, xsLoad, rxEvent} = 5'h00;
    end

    // m: {secAddrLoad, xsRead, xsTxInt, xsLoad, rxEvent}, held n cycles
    task automatic send(input logic [4:0] m, input int n);
        @(posedge clk);
        {secAddrLoad, xsRead, xsTxInt, xsLoad, rxEvent} <= m;
        repeat (n) @(posedge clk);
        {secAddrLoad, xsRead, xsTxInt, xsLoad, rxEvent} <= 5'h00;
    endtask : send
endmodule : msc_seq_model

/* File: testbench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import msc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic              clk;
    logic              reset_n;
    logic              regWrStrobe;
    logic              regRdStrobe;
    logic              rdLate;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic [DATA_W-1:0] regRdData;
    logic [DATA_W-1:0] cv;
    logic              rxEvent, xsLoad, xsTxInt, xsRead, secAddrLoad;
    logic              seqRun, serviceGo, masterClear;
    logic              irqVectorA, irqVectorB, irq;
    logic [1:0]        extAddrHi, selLineExtAddr, ex;
    logic [LINE_W-1:0] selectedLine, ln;
    logic [DATA_W-1:0] expQ[$];
    int                n_mismatch = 0;
    int                n_checks = 0;
    int                seed = 32'h2d762fe6;

    msc_system_control msc_system_control_inst (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .rxEvent(rxEvent), .xsLoad(xsLoad), .xsTxInt(xsTxInt), .xsRead(xsRead),
        .secAddrLoad(secAddrLoad), .seqRun(seqRun), .serviceGo(serviceGo),
        .masterClear(masterClear), .extAddrHi(extAddrHi), .selLineExtAddr(selLineExtAddr),
        .selectedLine(selectedLine), .irqVectorA(irqVectorA), .irqVectorB(irqVectorB), .irq(irq)
    );

    msc_seq_model msc_seq_model_inst (
        .clk(clk), .rxEvent(rxEvent), .xsLoad(xsLoad), .xsTxInt(xsTxInt),
        .xsRead(xsRead), .secAddrLoad(secAddrLoad)
    );

    // ------------------------------------------------------------
    // clock, compare and bus tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr     <= a;
        regWrData   <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        regAddr     <= a;
        regRdStrobe <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        regRdStrobe <= 1'b0;
        @(negedge clk);
    endtask : rd

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    // read data stand only in the cycle after the strobe edge
    always @(posedge clk) rdLate <= regRdStrobe;
    always @(negedge clk) begin
        if (rdLate === 1'b1) begin
            chk(regRdData, expQ.pop_front());
        end
    end

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, regWrStrobe, regRdStrobe} = 3'h0;
        regAddr   = 4'h0;
        regWrData = 16'h0000;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(OFF_SYS_CTRL, 16'h0000);
        rd(OFF_IRQ_STATUS, 16'h0000);
        rd(4'hf, 16'h0000);
        msc_seq_model_inst.send(5'h01, 1);
        rd(OFF_SYS_CTRL, 16'h0000);
        done("reset");
        // bits 7, 14, 15 written while write-enable is low must not stick
        wr(OFF_SYS_CTRL, 16'hf0f1);
        rd(OFF_SYS_CTRL, 16'h3071);
        chk(16'(seqRun), 16'h0001);
        chk(16'(extAddrHi), 16'h0003);
        wr(OFF_IRQ_ENABLE, 16'h0007);
        rd(OFF_IRQ_ENABLE, 16'h0007);
        msc_seq_model_inst.send(5'h01, 1);
        @(negedge clk);
        chk(16'(irqVectorA), 16'h0001);
        chk(16'(irqVectorB), 16'h0000);
        @(negedge clk);
        chk(16'(irq), 16'h0001);
        rd(OFF_IRQ_STATUS, 16'h0001);
        rd(OFF_SYS_CTRL, 16'h30f1);
        wr(OFF_SYS_CTRL, 16'h3031);
        @(negedge clk);
        chk(16'(irqVectorA), 16'h0000);
        // host has read the interrupt character before finishing service
        wr(OFF_SYS_CTRL, 16'h3171);
        @(negedge clk);
        chk(16'(serviceGo), 16'h0001);
        @(negedge clk);
        chk(16'(serviceGo), 16'h0000);
        rd(OFF_SYS_CTRL, 16'h3171);
        wr(OFF_IRQ_CLEAR, 16'h0001);
        rd(OFF_IRQ_STATUS, 16'h0000);
        chk(16'(irq), 16'h0000);
        done("receive");
        ln = 4'($random(seed));
        ex = 2'($random(seed));
        wr(OFF_SEC_SEL, 16'(ln));
        wr(OFF_SYS_CTRL, 16'h3041 | 16'(ex) << 4);
        msc_seq_model_inst.send(5'h10, 1);
        @(negedge clk);
        chk(16'(selLineExtAddr), 16'(ex));
        chk(16'(selectedLine), 16'(ln));
        // inverse kept to two bits so no higher control bit is hit
        cv = 16'h3041 | {10'h000, ~ex, 4'h0};
        wr(OFF_SYS_CTRL, cv);
        rd(OFF_SYS_CTRL, cv);
        rd(OFF_SEC_SEL, 16'(ln));
        chk(16'(selLineExtAddr), 16'(ex));
        done("extended address");
        msc_seq_model_inst.send(5'h06, 1);
        @(negedge clk);
        chk(16'(irqVectorB), 16'h0001);
        rd(OFF_SYS_CTRL, cv | 16'h8000);
        msc_seq_model_inst.send(5'h08, 1);
        @(negedge clk);
        chk(16'(irqVectorB), 16'h0000);
        wr(OFF_SYS_CTRL, cv | 16'h0200);
        wr(OFF_SYS_CTRL, cv | 16'h8280);
        rd(OFF_SYS_CTRL, cv | 16'h8280);
        wr(OFF_SYS_CTRL, 16'h0810);
        @(negedge clk);
        chk(16'(masterClear), 16'h0001);
        rd(OFF_SYS_CTRL, 16'h0010);
        chk(16'(seqRun), 16'h0000);
        done("status and clear");
        wr(OFF_SYS_CTRL, 16'h1001);
        msc_seq_model_inst.send(5'h02, 63);
        rd(OFF_SYS_CTRL, 16'h1001);
        msc_seq_model_inst.send(5'h02, 1);
        rd(OFF_SYS_CTRL, 16'h1401);
        chk(16'(irqVectorB), 16'h0001);
        wr(OFF_SYS_CTRL, 16'h0401);
        @(negedge clk);
        chk(16'(irqVectorB), 16'h0000);
        // receive bit was raised again by the maintenance write of bit 07
        rd(OFF_IRQ_STATUS, 16'h0007);
        wr(OFF_IRQ_CLEAR, 16'h0007);
        @(negedge clk);
        chk(16'(irq), 16'h0000);
        done("silo overflow");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(OFF_SYS_CTRL, 16'h0000);
        chk(16'(irqVectorB), 16'h0000);
        done("second reset");
        report_and_stop();
    end
endmodule : tb
